// [nvm_pkg.sv]
// Constants, types and decode helpers for the nonvolatile memory controller.
// Assumes one system clock and a processor that drives the register and table ports.
// Operation
// (R1) Program flash erased/programmed one 32-word row
// (R2) Key 0x55 then 0xAA precedes start bit
// (R3) Stall processor during program flash cycle
// (R4) Hardware clears start bit at cycle end
// (R5) Software loads all latches before row program
// (R6) High-byte latch write keeps only low byte
// (R7) Software writes 0x4041 then row address
// (R8) Data EEPROM lies at 0x7FF000 to 0x7FFFFE
// (R9) Data EEPROM supports word and 16-word blocks
// (R10) EEPROM completion waits on array, no count
// (R11) Data EEPROM operations never stall processor
// (R12) EEPROM reads during operation are undefined
// (R13) Software waits before next EEPROM operation
// (R14) Start bit set-only; writing zero ignored
// (R15) Write enable permits writes; power-up clears
// (R16) Interrupting reset sets write error flag
// (R17) Interrupting reset keeps address registers
// (R18) Completion sets done flag until cleared
// (R19) Software erases EEPROM word before writing
// (R20) Block erase: address, select, then start
// (R21) Software issues two no-ops after start
// (R22) Address registers capture last table address
// (R23) Program flash cycle nominally 2 ms, stalled
// (R24) Start needs write enable from earlier write
// (R25) Key register write-only, reads zero
// (R26) Keys must arrive on consecutive key writes
// (R27) Clearing write enable never aborts operation
package nvm_pkg;
    localparam int REG_ADDR_W = 16;
    localparam int REG_DATA_W = 16;
    localparam int EA_W = 24;
    localparam int OP_W = 7;
    localparam int LATCH_W = 24;
    localparam int ROW_WORDS = 32;
    localparam int EE_BLOCK_WORDS = 16;
    localparam int LATCH_IDX_W = 5;
    localparam logic [REG_ADDR_W-1:0] REG_CONTROL_ADDR = 16'h0760;
    localparam logic [REG_ADDR_W-1:0] REG_ADDR_LOW_ADDR = 16'h0762;
    localparam logic [REG_ADDR_W-1:0] REG_ADDR_UPPER_ADDR = 16'h0764;
    localparam logic [REG_ADDR_W-1:0] REG_KEY_ADDR = 16'h0766;
    localparam int CTL_START_BIT = 15;
    localparam int CTL_WRITE_ENABLE_BIT_BIT = 14;
    localparam int CTL_ERR_BIT = 13;
    localparam int CTL_BIT8_BIT = 8;
    localparam logic [REG_DATA_W-1:0] CTL_RESET = 16'h0000;
    localparam logic [EA_W-1:0] ADDR_RESET = 24'h000000;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    localparam logic [OP_W-1:0] OP_PF_ROW_ERASE = 7'h41;
    localparam logic [OP_W-1:0] OP_PF_ROW_PROG = 7'h01;
    localparam logic [OP_W-1:0] OP_EE_WORD_ERASE = 7'h44;
    localparam logic [OP_W-1:0] OP_EE_BLOCK_ERASE = 7'h45;
    localparam logic [OP_W-1:0] OP_EE_WORD_WRITE = 7'h04;
    localparam logic [OP_W-1:0] OP_EE_BLOCK_WRITE = 7'h05;
    localparam logic [EA_W-1:0] EE_BASE = 24'h7ff000;
    localparam logic [EA_W-1:0] EE_TOP = 24'h7ffffe;
    typedef enum logic {ST_IDLE, ST_RUN} ctl_state_type;

    // Address falls in data EEPROM window
    function automatic logic is_eeprom(input logic [EA_W-1:0] ea);
        is_eeprom = (ea >= EE_BASE) && (ea <= EE_TOP); // R8
    endfunction

    // Operation targets data EEPROM
    function automatic logic op_is_eeprom(input logic [OP_W-1:0] op);
        op_is_eeprom = (op == OP_EE_WORD_ERASE) || (op == OP_EE_BLOCK_ERASE) ||
                       (op == OP_EE_WORD_WRITE) || (op == OP_EE_BLOCK_WRITE);
    endfunction
endpackage

// [nvm_link_if.sv]
// Bundle between the controller and its key and latch units.
// Assumes all three share clk_sys; no timing is carried here.
`timescale 1ns/1ps
`default_nettype none
interface nvm_link_if;
    logic key_wr;
    logic [7:0] key_data;
    logic key_other;
    logic key_armed;
    logic lat_wr_low;
    logic lat_wr_high;
    logic [nvm_pkg::LATCH_IDX_W-1:0] lat_idx;
    logic [15:0] lat_data;
    logic [nvm_pkg::LATCH_IDX_W-1:0] lat_rd_idx;
    logic [nvm_pkg::LATCH_W-1:0] lat_rd_data;
    modport key_ctl (output key_wr, key_data, key_other, input key_armed);
    modport key_unit (input key_wr, key_data, key_other, output key_armed);
    modport lat_ctl (output lat_wr_low, lat_wr_high, lat_idx, lat_data, lat_rd_idx, input lat_rd_data);
    modport lat_unit (input lat_wr_low, lat_wr_high, lat_idx, lat_data, lat_rd_idx, output lat_rd_data);
endinterface
`default_nettype wire

// [nvm_unlock_key.sv]
// Unlock key detector: arms after the two key values in back-to-back key writes.
// Assumes key_other pulses on every other register or table write and on warm reset.
`timescale 1ns/1ps
`default_nettype none
module nvm_unlock_key
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Key traffic
    nvm_link_if.key_unit link
);
    import nvm_pkg::*;

    logic first_ff;
    logic armed_ff;

    always_ff @(posedge clk_sys)
    begin
        if (srst || link.key_other)
        begin
            first_ff <= 1'b0; // R26
            armed_ff <= 1'b0;
        end
        else if (link.key_wr)
        begin
            first_ff <= (link.key_data == KEY_FIRST); // R2
            armed_ff <= first_ff && (link.key_data == KEY_SECOND); // R26
        end
    end

    assign link.key_armed = armed_ff;
endmodule
`default_nettype wire

// [nvm_write_latches.sv]
// Row write latches shared by program flash rows and data EEPROM blocks.
// Assumes the controller blocks latch writes while an operation runs.
`timescale 1ns/1ps
`default_nettype none
module nvm_write_latches
#(
    parameter int WORDS = nvm_pkg::ROW_WORDS,
    parameter int WIDTH = nvm_pkg::LATCH_W
)
(
    // Clock
    input wire logic clk_sys,
    // Latch traffic
    nvm_link_if.lat_unit link
);
    import nvm_pkg::*;

    logic [WIDTH-1:0] latch_mem [WORDS];
    logic [WIDTH-1:0] rd_data_ff;

    always_ff @(posedge clk_sys)
    begin
        if (link.lat_wr_low)
            latch_mem[link.lat_idx][15:0] <= link.lat_data;
        if (link.lat_wr_high)
            latch_mem[link.lat_idx][WIDTH-1:16] <= link.lat_data[WIDTH-17:0]; // R6
    end

    always_ff @(posedge clk_sys)
    begin
        rd_data_ff <= latch_mem[link.lat_rd_idx];
    end

    assign link.lat_rd_data = rd_data_ff;
endmodule
`default_nettype wire

// [nvm_program_erase_controller.sv]
// Program flash and data EEPROM erase/program sequencer with its control registers.
// Assumes an array macro that performs the cycle and pulses mac_done when finished.
`timescale 1ns/1ps
`default_nettype none
module nvm_program_erase_controller
(
    // Clock and resets
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic warm_reset,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [nvm_pkg::REG_ADDR_W-1:0] reg_addr,
    input wire logic [nvm_pkg::REG_DATA_W-1:0] reg_wdata,
    output logic [nvm_pkg::REG_DATA_W-1:0] reg_rdata,
    // Table instruction port
    input wire logic tbl_wr_low,
    input wire logic tbl_wr_high,
    input wire logic tbl_rd,
    input wire logic [nvm_pkg::EA_W-1:0] tbl_ea,
    input wire logic [15:0] tbl_wdata,
    // Processor status
    output logic cpu_stall,
    output logic done_flag,
    input wire logic done_flag_clr,
    // Array macro
    output logic mac_start,
    output logic [nvm_pkg::OP_W-1:0] mac_cmd,
    output logic [nvm_pkg::EA_W-1:0] mac_row_addr,
    input wire logic mac_done,
    input wire logic [nvm_pkg::LATCH_IDX_W-1:0] mac_latch_idx,
    output logic [nvm_pkg::LATCH_W-1:0] mac_latch_data
);
    import nvm_pkg::*;

    nvm_link_if link ();

    ctl_state_type state_ff;
    ctl_state_type nxt_state;

    logic wr_bit_ff;
    logic write_enable_bit_ff;
    logic err_ff;
    logic bit8_ff;
    logic [OP_W-1:0] op_ff;
    logic [15:0] addr_low_ff;
    logic [7:0] addr_upper_ff;
    logic [REG_DATA_W-1:0] rdata_ff;
    logic done_ff;
    logic mac_start_ff;
    logic [OP_W-1:0] mac_cmd_ff;
    logic [EA_W-1:0] mac_row_addr_ff;
    logic run_eeprom_ff;

    logic ctl_hit;
    logic low_hit;
    logic upper_hit;
    logic key_hit;
    logic idle;
    logic op_known;
    logic start_ok;
    logic finish;
    logic tbl_any;
    logic tbl_in_ee;
    logic [EA_W-1:0] cur_addr;
    logic [EA_W-1:0] nxt_row_addr;
    logic [REG_DATA_W-1:0] nxt_rdata;

    // Register write aimed at one address
    function automatic logic reg_hit(input logic wr, input logic [REG_ADDR_W-1:0] addr,
                                     input logic [REG_ADDR_W-1:0] target);
        reg_hit = wr && (addr == target);
    endfunction

    // Register decode
    assign ctl_hit = reg_hit(reg_wr, reg_addr, REG_CONTROL_ADDR);
    assign low_hit = reg_hit(reg_wr, reg_addr, REG_ADDR_LOW_ADDR);
    assign upper_hit = reg_hit(reg_wr, reg_addr, REG_ADDR_UPPER_ADDR);
    assign key_hit = reg_hit(reg_wr, reg_addr, REG_KEY_ADDR);
    assign tbl_in_ee = is_eeprom(tbl_ea); // R8
    assign idle = (state_ff == ST_IDLE);
    assign tbl_any = tbl_wr_low || tbl_wr_high || tbl_rd;
    assign cur_addr = {addr_upper_ff, addr_low_ff};

    // Recognised operation codes
    assign op_known = (op_ff == OP_PF_ROW_ERASE) || (op_ff == OP_PF_ROW_PROG) ||
                      op_is_eeprom(op_ff);

    // Start request: keys armed, write enable already stored, start bit written
    assign start_ok = ctl_hit && reg_wdata[CTL_START_BIT] && write_enable_bit_ff && // R24
                      link.key_armed && idle && op_known && !warm_reset; // R2 R20

    // Completion comes only from the array, whatever the duration
    assign finish = (state_ff == ST_RUN) && mac_done && !warm_reset; // R10 R23

    // Key unit traffic
    assign link.key_wr = key_hit && !warm_reset;
    assign link.key_data = reg_wdata[7:0];
    assign link.key_other = (reg_wr && !key_hit) || tbl_wr_low || tbl_wr_high ||
                            warm_reset; // R26

    // Latch unit traffic, writes blocked while an operation runs
    assign link.lat_wr_low = tbl_wr_low && idle;
    assign link.lat_wr_high = tbl_wr_high && idle && !tbl_in_ee; // R6 R8
    assign link.lat_idx = tbl_in_ee ? {1'b0, tbl_ea[4:1]} : tbl_ea[5:1]; // R1 R9
    assign link.lat_data = tbl_wdata;
    assign link.lat_rd_idx = mac_latch_idx;

    nvm_unlock_key u_key
    (
        .clk_sys (clk_sys),
        .srst (srst),
        .link (link.key_unit)
    );

    nvm_write_latches #(
        .WORDS (ROW_WORDS),
        .WIDTH (LATCH_W)
    ) u_latch
    (
        .clk_sys (clk_sys),
        .link (link.lat_unit)
    );

    // Sequencer state
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (start_ok)
                    nxt_state = ST_RUN;
            end
            ST_RUN:
            begin
                if (finish || warm_reset)
                    nxt_state = ST_IDLE;
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            state_ff <= ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    // Start bit: set by a valid start, cleared only by hardware
    always_ff @(posedge clk_sys)
    begin
        if (srst || warm_reset)
            wr_bit_ff <= 1'b0;
        else if (start_ok)
            wr_bit_ff <= 1'b1; // R14
        else if (finish)
            wr_bit_ff <= 1'b0; // R4
    end

    // Write enable: cleared at power-up and by resets, free to change while running
    always_ff @(posedge clk_sys)
    begin
        if (srst || warm_reset)
            write_enable_bit_ff <= CTL_RESET[CTL_WRITE_ENABLE_BIT_BIT]; // R15
        else if (ctl_hit)
            write_enable_bit_ff <= reg_wdata[CTL_WRITE_ENABLE_BIT_BIT]; // R27
    end

    // Write error: set by a reset that cuts an operation short
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            err_ff <= CTL_RESET[CTL_ERR_BIT];
        else if (warm_reset && !idle)
            err_ff <= 1'b1; // R16
        else if (ctl_hit)
            err_ff <= reg_wdata[CTL_ERR_BIT];
    end

    // Operation select and spare control bit, frozen while running
    always_ff @(posedge clk_sys)
    begin
        if (srst || warm_reset)
        begin
            bit8_ff <= CTL_RESET[CTL_BIT8_BIT];
            op_ff <= CTL_RESET[OP_W-1:0];
        end
        else if (ctl_hit && idle)
        begin
            bit8_ff <= reg_wdata[CTL_BIT8_BIT];
            op_ff <= reg_wdata[OP_W-1:0];
        end
    end

    // Address registers: table capture or direct write; warm reset leaves them
    always_ff @(posedge clk_sys)
    begin
        if (srst) // R17
        begin
            addr_low_ff <= ADDR_RESET[15:0];
            addr_upper_ff <= ADDR_RESET[EA_W-1:16];
        end
        else if (idle && tbl_any)
        begin
            addr_low_ff <= tbl_ea[15:0]; // R22
            addr_upper_ff <= tbl_ea[EA_W-1:16];
        end
        else if (idle && low_hit)
        begin
            addr_low_ff <= reg_wdata;
        end
        else if (idle && upper_hit)
        begin
            addr_upper_ff <= reg_wdata[7:0];
        end
    end

    // Array address for the operation: row, block or word alignment
    always_comb
    begin
        nxt_row_addr = cur_addr;
        case (op_ff)
            OP_PF_ROW_ERASE, OP_PF_ROW_PROG:
            begin
                nxt_row_addr = {cur_addr[EA_W-1:6], 6'h00}; // R1
            end
            OP_EE_BLOCK_ERASE, OP_EE_BLOCK_WRITE:
            begin
                nxt_row_addr = {cur_addr[EA_W-1:5], 5'h00}; // R9 R20
            end
            OP_EE_WORD_ERASE, OP_EE_WORD_WRITE:
            begin
                nxt_row_addr = {cur_addr[EA_W-1:1], 1'b0}; // R9
            end
            default:
            begin
                nxt_row_addr = cur_addr;
            end
        endcase
    end

    // Command to the array macro
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            mac_start_ff <= 1'b0;
            mac_cmd_ff <= CTL_RESET[OP_W-1:0];
            mac_row_addr_ff <= ADDR_RESET;
            run_eeprom_ff <= 1'b0;
        end
        else
        begin
            mac_start_ff <= start_ok;
            if (start_ok)
            begin
                mac_cmd_ff <= op_ff;
                mac_row_addr_ff <= nxt_row_addr;
                run_eeprom_ff <= op_is_eeprom(op_ff);
            end
        end
    end

    // Processor stall: program flash cycles only, EEPROM runs in background
    assign cpu_stall = (state_ff == ST_RUN) && !run_eeprom_ff; // R3 R11 R23

    // Done flag: set on completion, held until cleared, set wins
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            done_ff <= 1'b0;
        else if (finish)
            done_ff <= 1'b1; // R18
        else if (done_flag_clr)
            done_ff <= 1'b0;
    end

    // Register read mux; key register reads zero
    always_comb
    begin
        nxt_rdata = '0;
        case (reg_addr)
            REG_CONTROL_ADDR:
            begin
                nxt_rdata[CTL_START_BIT] = wr_bit_ff;
                nxt_rdata[CTL_WRITE_ENABLE_BIT_BIT] = write_enable_bit_ff;
                nxt_rdata[CTL_ERR_BIT] = err_ff;
                nxt_rdata[CTL_BIT8_BIT] = bit8_ff;
                nxt_rdata[OP_W-1:0] = op_ff;
            end
            REG_ADDR_LOW_ADDR:
            begin
                nxt_rdata = addr_low_ff;
            end
            REG_ADDR_UPPER_ADDR:
            begin
                nxt_rdata[7:0] = addr_upper_ff;
            end
            REG_KEY_ADDR:
            begin
                nxt_rdata = '0; // R25
            end
            default:
            begin
                nxt_rdata = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            rdata_ff <= '0;
        else if (reg_rd)
            rdata_ff <= nxt_rdata;
    end

    // Table reads only capture the address; array data during a run is not guarded
    // and reads of data EEPROM then return whatever the array gives. R12

    assign reg_rdata = rdata_ff;
    assign done_flag = done_ff;
    assign mac_start = mac_start_ff;
    assign mac_cmd = mac_cmd_ff;
    assign mac_row_addr = mac_row_addr_ff;
    assign mac_latch_data = link.lat_rd_data;
endmodule
`default_nettype wire

// [nvm_pec_properties.sv]
// Port checker for the erase/program controller.
// Assumes binding into nvm_program_erase_controller.
`timescale 1ns/1ps
`default_nettype none
module nvm_pec_properties
(
    // Clock and resets
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic warm_reset,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [nvm_pkg::REG_ADDR_W-1:0] reg_addr,
    input wire logic [nvm_pkg::REG_DATA_W-1:0] reg_wdata,
    input wire logic [nvm_pkg::REG_DATA_W-1:0] reg_rdata,
    // Status and macro
    input wire logic cpu_stall,
    input wire logic done_flag,
    input wire logic done_flag_clr,
    input wire logic mac_start,
    input wire logic [nvm_pkg::OP_W-1:0] mac_cmd,
    input wire logic [nvm_pkg::EA_W-1:0] mac_row_addr,
    input wire logic mac_done
);
    import nvm_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    a_start_cause: assert property (
        mac_start |-> $past(reg_wr && reg_addr == 16'h0760 && reg_wdata[15])) else $error("start without start write");
    a_flash_stall: assert property (
        mac_start && !mac_cmd[2] |-> cpu_stall) else $error("flash cycle not stalling");
    a_eeprom_free: assert property (
        mac_start && mac_cmd[2] |-> !cpu_stall) else $error("eeprom cycle stalls");
    a_stall_hold: assert property (
        cpu_stall && !mac_done && !warm_reset |=> cpu_stall) else $error("stall dropped early");
    a_cycle_end: assert property (
        cpu_stall && mac_done && !warm_reset |=> !cpu_stall && done_flag) else $error("cycle end wrong");
    a_done_keep: assert property (
        done_flag && !done_flag_clr |=> done_flag) else $error("done flag lost");
    a_done_cause: assert property (
        $rose(done_flag) |-> $past(mac_done)) else $error("done flag without completion");
    a_key_hidden: assert property (
        reg_rd && reg_addr == 16'h0766 |=> reg_rdata == 16'h0000) else $error("key readable");
    a_row_align: assert property (
        mac_start && !mac_cmd[2] |-> mac_row_addr[5:0] == 6'h00) else $error("row not aligned");
    a_warm_idle: assert property (
        warm_reset |=> !cpu_stall) else $error("warm reset left stall");
    c_flash: cover property (mac_start && !mac_cmd[2]);
    c_eeprom: cover property (mac_start && mac_cmd[2]);
    c_warm: cover property (warm_reset && cpu_stall);
endmodule
bind nvm_program_erase_controller nvm_pec_properties chk_u (.*);
`default_nettype wire

// [nvm_array_model.sv]
// Array macro model: answers each start with a done pulse after a set delay.
// Assumes a one-cycle mac_start; drives on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module nvm_array_model
(
    // Clock
    input wire logic clk_sys,
    // Macro handshake
    input wire logic mac_start,
    input wire logic [7:0] dly,
    output logic mac_done
);
    logic busy_ff;
    logic [7:0] cnt_ff;
    initial
    begin
        mac_done = 1'b0;
        busy_ff = 1'b0;
    end
    // Duration varies per operation
    always @(negedge clk_sys)
    begin
        mac_done <= 1'b0;
        if (mac_start)
        begin
            busy_ff <= 1'b1;
            cnt_ff <= dly;
        end
        else if (busy_ff && cnt_ff == 8'h00)
        begin
            busy_ff <= 1'b0;
            mac_done <= 1'b1;
        end
        else if (busy_ff)
            cnt_ff <= cnt_ff - 8'h01;
    end
endmodule
`default_nettype wire

// [nvm_program_erase_controller_tb.sv]
// Testbench for the erase/program controller.
// Assumes the array model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module nvm_program_erase_controller_tb;
    import nvm_pkg::*;
    logic clk_sys, srst, warm_reset, reg_wr, reg_rd, tbl_wr_low, tbl_wr_high, tbl_rd, done_flag_clr;
    logic cpu_stall, done_flag, mac_start, mac_done;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, tbl_wdata, d;
    logic [23:0] tbl_ea, mac_row_addr, mac_latch_data;
    logic [6:0] mac_cmd;
    logic [4:0] mac_latch_idx;
    logic [7:0] dly;
    int mismatches = 0;
    int comparisons = 0;
    nvm_program_erase_controller dut_u (.*);
    nvm_array_model mdl_u (.*);
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        comparisons++;
        if (g !== e)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(negedge clk_sys);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, v};
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(negedge clk_sys);
        {reg_rd, reg_addr} = {1'b1, a};
        @(negedge clk_sys);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
    task automatic tw(input logic [2:0] k, input logic [23:0] ea, input logic [15:0] v);
        @(negedge clk_sys);
        {tbl_rd, tbl_wr_high, tbl_wr_low, tbl_ea, tbl_wdata} = {k, ea, v};
        @(negedge clk_sys);
        {tbl_rd, tbl_wr_high, tbl_wr_low} = 3'b000;
    endtask
    task automatic keys;
        wr(16'h0766, 16'h0055);
        wr(16'h0766, 16'h00aa);
    endtask
    task automatic clr_done;
        @(negedge clk_sys);
        done_flag_clr = 1'b1;
        @(negedge clk_sys);
        done_flag_clr = 1'b0;
    endtask
    task automatic wait_done;
        for (int n = 0; n < 200 && done_flag !== 1'b1; n++)
            @(negedge clk_sys);
        chk("done_flag", 1'b1, done_flag);
    endtask
    task automatic t_reset;
        rd(16'h0760);
        chk("control", CTL_RESET, d);
        rd(16'h0766);
        chk("key", 16'h0000, d);
        rd(16'h0768);
        chk("unmapped", 16'h0000, d);
    endtask
    task automatic t_latch;
        tw(3'b001, 24'h006000, 16'h1234);
        tw(3'b010, 24'h006000, 16'hab56);
        tw(3'b001, 24'h00603e, 16'h0f0f);
        tw(3'b010, 24'h00603e, 16'h1122);
        mac_latch_idx = 5'h1f;
        @(negedge clk_sys);
        chk("latch31", 24'h220f0f, mac_latch_data);
        mac_latch_idx = 5'h00;
        @(negedge clk_sys);
        chk("latch0", 24'h561234, mac_latch_data);
        rd(16'h0762);
        chk("addr_low", 16'h603e, d);
    endtask
    task automatic t_flash;
        dly = 8'd20;
        wr(16'h0760, 16'h4041);
        wr(16'h0764, 16'h0000);
        wr(16'h0762, 16'h6040);
        keys();
        wr(16'h0760, 16'hc041);
        chk("mac_start", 1'b1, mac_start);
        chk("cpu_stall", 1'b1, cpu_stall);
        chk("mac_cmd", OP_PF_ROW_ERASE, mac_cmd);
        chk("mac_row_addr", 24'h006040, mac_row_addr);
        rd(16'h0760);
        chk("start_bit", 1'b1, d[15]);
        wait_done();
        chk("cpu_stall", 1'b0, cpu_stall);
        rd(16'h0760);
        chk("control", 16'h4041, d);
        clr_done();
        chk("done_flag", 1'b0, done_flag);
    endtask
    task automatic t_refuse;
        for (int i = 0; i < 3; i++)
        begin
            if (i == 2)
                wr(16'h0760, 16'h0041);
            if (i > 0)
                wr(16'h0766, 16'h0055);
            if (i == 1)
                wr(16'h0762, 16'h6040);
            if (i > 0)
                wr(16'h0766, 16'h00aa);
            wr(16'h0760, 16'hc041);
            chk("refused_start", 1'b0, mac_start);
        end
    endtask
    task automatic t_eeprom;
        dly = 8'd45;
        tw(3'b100, 24'h7ff020, 16'h0000);
        rd(16'h0762);
        chk("addr_low", 16'hf020, d);
        rd(16'h0764);
        chk("addr_upper", 16'h007f, d);
        wr(16'h0760, 16'h4045);
        keys();
        wr(16'h0760, 16'hc045);
        chk("mac_start", 1'b1, mac_start);
        chk("cpu_stall", 1'b0, cpu_stall);
        chk("mac_cmd", OP_EE_BLOCK_ERASE, mac_cmd);
        chk("mac_row_addr", 24'h7ff020, mac_row_addr);
        wr(16'h0760, 16'h0000);
        rd(16'h0760);
        chk("start_bit", 1'b1, d[15]);
        wait_done();
        rd(16'h0760);
        chk("write_enable_bit_start", 2'b00, d[15:14]);
        tw(3'b010, 24'h006002, 16'h9977);
        tw(3'b001, 24'h7ff022, 16'hbeef);
        tw(3'b010, 24'h7ff022, 16'h0033);
        mac_latch_idx = 5'h01;
        @(negedge clk_sys);
        chk("ee_latch", 24'h77beef, mac_latch_data);
        clr_done();
        wr(16'h0760, 16'h4004);
        keys();
        wr(16'h0760, 16'hc004);
        chk("mac_start", 1'b1, mac_start);
        chk("mac_cmd", OP_EE_WORD_WRITE, mac_cmd);
        chk("mac_row_addr", 24'h7ff022, mac_row_addr);
        chk("cpu_stall", 1'b0, cpu_stall);
        repeat (2) @(negedge clk_sys);
        wait_done();
    endtask
    task automatic t_warm;
        dly = 8'd10;
        clr_done();
        wr(16'h0760, 16'h4001);
        keys();
        wr(16'h0760, 16'hc001);
        chk("cpu_stall", 1'b1, cpu_stall);
        @(negedge clk_sys);
        warm_reset = 1'b1;
        @(negedge clk_sys);
        warm_reset = 1'b0;
        chk("cpu_stall", 1'b0, cpu_stall);
        rd(16'h0760);
        chk("control", 16'h2000, d);
        rd(16'h0762);
        chk("addr_low", 16'hf022, d);
        rd(16'h0764);
        chk("addr_upper", 16'h007f, d);
        repeat (20) @(negedge clk_sys);
        chk("done_flag", 1'b0, done_flag);
    endtask
    initial
    begin
        #20000;
        mismatches++;
        conclude();
    end
    initial
    begin
        {srst, warm_reset, reg_wr, reg_rd, tbl_wr_low, tbl_wr_high, tbl_rd, done_flag_clr} = 8'h80;
        {reg_addr, reg_wdata, tbl_wdata, tbl_ea} = 72'h0;
        {mac_latch_idx, dly} = 13'h0014;
        repeat (6) @(negedge clk_sys);
        srst = 1'b0;
        t_reset();
        t_latch();
        t_flash();
        t_refuse();
        t_eeprom();
        t_warm();
        conclude();
    end
endmodule
`default_nettype wire
